// File: drive_control_status_words.sv
`timescale 1ns/1ps
`default_nettype none
module drive_control_status_words
  import drive_cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // Wishbone slave.
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Local sequencer inputs and sequencer feedback.
  input  wire seq_in_t     i_local,
  input  wire seq_out_t    i_seq,
  input  wire seq_state_t  i_seq_state,
  input  wire drive_cond_t i_cond,
  // Inputs to the sequencer.
  output seq_in_t          o_seq_in,
  output logic             o_fault_reset_pulse,
  output logic             o_leave_tripped
);

  ////////////////////////////////////////////////////////////////////////////

  logic [15:0] cmd_q;
  logic [2:0]  mode_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        clr_prev_q;
  seq_in_t     seq_in_q;
  logic        pulse_q;
  logic [15:0] status_q;

  function automatic logic [15:0] merge_lo(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
    merge_lo = {sel[1] ? dat[15:8] : old[15:8],
                sel[0] ? dat[7:0]  : old[7:0]};
  endfunction : merge_lo

  ////////////////////////////////////////////////////////////////////////////

  wire req      = i_wb_cyc & i_wb_stb & ~ack_q;
  wire wr       = req & i_wb_we;
  wire hit_cmd  = i_wb_adr == CMD_WORD_OFS;
  wire hit_stat = i_wb_adr == STATUS_WORD_OFS;
  wire hit_mode = i_wb_adr == MODE_CTRL_OFS;
  wire hit_st   = i_wb_adr == SEQ_STATE_OFS;
  wire net_mode = mode_q[MODE_NETWORK];
  wire [15:0] mode_wr = merge_lo({13'h0000, mode_q}, i_wb_dat, i_wb_sel);

  // The command word only steers the sequencer in network mode.
  wire run_cmd = cmd_q[CMD_SWITCH_ON];
  seq_in_t seq_in_d;
  assign seq_in_d.run_forward = net_mode ? run_cmd
                                         : i_local.run_forward;
  assign seq_in_d.run_reverse = net_mode ? 1'b0 : i_local.run_reverse;
  assign seq_in_d.stop_hold_n = net_mode ? 1'b0 : i_local.stop_hold_n;
  assign seq_in_d.coast_stop_n = i_local.coast_stop_n
                               & (~net_mode | cmd_q[CMD_COAST_N]);
  assign seq_in_d.quick_halt_n = i_local.quick_halt_n
                               & (~net_mode | cmd_q[CMD_RAPID_N]);
  assign seq_in_d.drive_operate_enable = i_local.drive_operate_enable
                               & (~net_mode | cmd_q[CMD_ENABLE_OP]);
  assign seq_in_d.fault_clear = net_mode ? cmd_q[CMD_FAULT_CLR]
                                         : i_local.fault_clear;

  // Status bits are assembled each cycle from sequencer feedback, the coast and halt sources, the mode bits and the drive conditions.
  logic [15:0] status_d;
  always_comb begin
    status_d     = 16'h0000;
    status_d[0]  = i_seq.start_permitted;
    status_d[1]  = i_seq.power_stage_on;
    status_d[2]  = i_seq.running;
    status_d[3]  = i_seq.tripped;
    status_d[4]  = net_mode ? cmd_q[CMD_COAST_N] : i_local.coast_stop_n;
    status_d[5]  = net_mode ? cmd_q[CMD_RAPID_N] : i_local.quick_halt_n;
    status_d[6]  = i_seq_state == SEQ_START_INHIBIT;
    status_d[9]  = mode_q[MODE_REMOTE] & mode_q[MODE_COMMS_SEL];
    status_d[10] = ~i_cond.ramping;
    status_d[11] = i_cond.vector_mode ? i_cond.speed_torque_limit
                                      : i_cond.vhz_current_limit;
    status_d     = status_d & STATUS_MASK;
  end

  // A trip is left only on a clean rising edge of the fault clear.
  wire pulse_d = seq_in_d.fault_clear & ~clr_prev_q;

  logic [31:0] rdat_d;
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (hit_cmd) begin
      rdat_d[15:0] = cmd_q;
    end else if (hit_stat) begin
      rdat_d[15:0] = status_q;
    end else if (hit_mode) begin
      rdat_d[2:0] = mode_q;
    end else if (hit_st) begin
      rdat_d[2:0] = i_seq_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Unmapped addresses are still acknowledged and read zero so that a
  // stray access never hangs the bus master.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q      <= CMD_WORD_RST;
      mode_q     <= MODE_CTRL_RST;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h0000_0000;
      clr_prev_q <= 1'b0;
      seq_in_q   <= '0;
      pulse_q    <= 1'b0;
      status_q   <= 16'h0000;
    end else begin
      ack_q      <= req;
      rdat_q     <= req ? rdat_d : rdat_q;
      if (wr && hit_cmd) begin
        cmd_q <= merge_lo(cmd_q, i_wb_dat, i_wb_sel);
      end
      if (wr && hit_mode) begin
        mode_q <= mode_wr[2:0];
      end
      clr_prev_q <= seq_in_d.fault_clear;
      seq_in_q   <= seq_in_d;
      pulse_q    <= pulse_d;
      status_q   <= status_d;
    end
  end

  assign o_wb_ack            = ack_q;
  assign o_wb_dat            = rdat_q;
  assign o_seq_in            = seq_in_q;
  assign o_fault_reset_pulse = pulse_q;
  assign o_leave_tripped     = pulse_q & ~i_seq.trip_condition
                             & (i_seq_state == SEQ_TRIPPED);

  ////////////////////////////////////////////////////////////////////////////

  sequence cmd_write_s;
    wr && hit_cmd && (i_wb_sel[1:0] == 2'h3);
  endsequence

  cmd_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cmd_write_s |=> cmd_q == $past(i_wb_dat[15:0]))
    else $error("Command word did not take the write.");

  cmd_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(wr && hit_cmd) |=> $stable(cmd_q))
    else $error("Command word changed without a write.");

  run_map_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_mode |=> o_seq_in.run_forward == $past(cmd_q[0])
                 && !o_seq_in.run_reverse && !o_seq_in.stop_hold_n)
    else $error("Run mapping wrong in network mode.");

  coast_and_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_mode |=> o_seq_in.coast_stop_n
      == ($past(cmd_q[1]) && $past(i_local.coast_stop_n)))
    else $error("Coast stop is not the AND of both sources.");

  halt_and_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_mode |=> o_seq_in.quick_halt_n
      == ($past(cmd_q[2]) && $past(i_local.quick_halt_n)))
    else $error("Quick halt is not the AND of both sources.");

  enable_and_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_mode |=> o_seq_in.drive_operate_enable
      == ($past(cmd_q[3]) && $past(i_local.drive_operate_enable)))
    else $error("Operate enable is not the AND of both sources.");

  clear_edge_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(seq_in_d.fault_clear) |=> o_fault_reset_pulse ##1
      !o_fault_reset_pulse)
    else $error("Fault clear edge did not give a one-cycle pulse.");

  stat_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (status_q & ~STATUS_MASK) == 16'h0000)
    else $error("Unsupported status bits are not zero.");

  stat_seq_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> status_q[3:0] == {$past(i_seq.tripped), $past(i_seq.running),
                               $past(i_seq.power_stage_on),
                               $past(i_seq.start_permitted)})
    else $error("Status bits 0 to 3 do not follow the sequencer.");

  inhibit_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> status_q[6] == ($past(i_seq_state) == SEQ_START_INHIBIT))
    else $error("Start inhibit bit wrong.");

  ramp_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> status_q[10] == !$past(i_cond.ramping))
    else $error("Setpoint reached bit wrong.");

  // The leave request is checked against the clear history, not against
  // the pulse register itself, so a broken edge detector shows up here.
  trip_leave_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_leave_tripped |-> !i_seq.trip_condition
      && (i_seq_state == SEQ_TRIPPED)
      && $past(seq_in_d.fault_clear) && !$past(clr_prev_q))
    else $error("Trip left without clean reset edge.");

  ////////////////////////////////////////////////////////////////////////////

  sequence net_s;
    net_mode;
  endsequence

  sequence local_s;
    !net_mode;
  endsequence

  sequence bus_read_s;
    req && !i_wb_we;
  endsequence

  sequence ack_once_s;
    o_wb_ack ##1 !o_wb_ack;
  endsequence

  coast_stat_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_s |=> status_q[4] == $past(cmd_q[CMD_COAST_N]))
    else $error("Status bit 4 does not copy the command in network mode.");

  coast_local_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    local_s |=> status_q[4] == $past(i_local.coast_stop_n))
    else $error("Status bit 4 does not copy the local coast input.");

  halt_stat_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_s |=> status_q[5] == $past(cmd_q[CMD_RAPID_N]))
    else $error("Status bit 5 does not copy the command in network mode.");

  halt_local_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    local_s |=> status_q[5] == $past(i_local.quick_halt_n))
    else $error("Status bit 5 does not copy the local halt input.");

  remote_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> status_q[9] == $past(mode_q[MODE_REMOTE]
                                  && mode_q[MODE_COMMS_SEL]))
    else $error("Remote status bit wrong.");

  limit_vec_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_cond.vector_mode |=> status_q[11] == $past(i_cond.speed_torque_limit))
    else $error("Limit bit wrong in vector mode.");

  limit_vhz_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !i_cond.vector_mode |=> status_q[11] == $past(i_cond.vhz_current_limit))
    else $error("Limit bit wrong in volts per hertz mode.");

  local_pass_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    local_s |=> o_seq_in == $past(i_local))
    else $error("Local inputs do not pass through outside network mode.");

  clear_map_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_s |=> o_seq_in.fault_clear == $past(cmd_q[CMD_FAULT_CLR]))
    else $error("Fault clear does not follow command bit 7.");

  run_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    net_s ##0 !cmd_q[CMD_SWITCH_ON] |=> !o_seq_in.run_forward)
    else $error("Run forward set while switch on is clear.");

  pulse_single_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_fault_reset_pulse |=> !o_fault_reset_pulse)
    else $error("Fault reset pulse longer than one cycle.");

  mode_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(wr && hit_mode) |=> $stable(mode_q))
    else $error("Mode changed without a write.");

  ack_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    req |=> ack_once_s)
    else $error("Acknowledge is not a one-cycle answer.");

  ack_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !req |=> !o_wb_ack)
    else $error("Acknowledge without a request.");

  read_upper_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
    else $error("Upper read data bits are not zero.");

  stat_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    bus_read_s ##0 hit_stat |=> o_wb_dat[15:0] == $past(status_q))
    else $error("Status read returned the wrong word.");

  cmd_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    bus_read_s ##0 hit_cmd |=> o_wb_dat[15:0] == $past(cmd_q))
    else $error("Command read returned the wrong word.");

  rdat_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !req |=> $stable(o_wb_dat))
    else $error("Read data changed without a request.");

endmodule : drive_control_status_words
`default_nettype wire

// File: drive_cmd_pkg.sv
package drive_cmd_pkg;

  // Register word offsets (byte addresses on the Wishbone bus).
  localparam logic [3:0]  CMD_WORD_OFS     = 4'h0;
  localparam logic [3:0]  STATUS_WORD_OFS  = 4'h4;
  localparam logic [3:0]  MODE_CTRL_OFS    = 4'h8;
  localparam logic [3:0]  SEQ_STATE_OFS    = 4'hc;

  // Reset values.
  localparam logic [15:0] CMD_WORD_RST     = 16'h0000;
  localparam logic [2:0]  MODE_CTRL_RST    = 3'h0;

  // Command word bit positions.
  localparam int CMD_SWITCH_ON  = 0;
  localparam int CMD_COAST_N    = 1;
  localparam int CMD_RAPID_N    = 2;
  localparam int CMD_ENABLE_OP  = 3;
  localparam int CMD_FAULT_CLR  = 7;

  // Mode control bit positions.
  localparam int MODE_NETWORK   = 0;
  localparam int MODE_REMOTE    = 1;
  localparam int MODE_COMMS_SEL = 2;

  // Status word mask: bits 7, 8 and 12 to 15 are always zero.
  localparam logic [15:0] STATUS_MASK = 16'h0e7f;

  // Sequencer states as seen by this block.
  typedef enum logic [2:0] {
    SEQ_START_INHIBIT,
    SEQ_READY_ON,
    SEQ_SWITCHED_ON,
    SEQ_READY,
    SEQ_ENABLED,
    SEQ_RAPID_STOP,
    SEQ_TRIP_ACTIVE,
    SEQ_TRIPPED
  } seq_state_t;

  // Local sequencer inputs, from terminals.
  typedef struct packed {
    logic run_forward;
    logic run_reverse;
    logic stop_hold_n;
    logic coast_stop_n;
    logic quick_halt_n;
    logic drive_operate_enable;
    logic fault_clear;
  } seq_in_t;

  // Sequencer outputs feeding the status word and the trip leave logic.
  typedef struct packed {
    logic start_permitted;
    logic power_stage_on;
    logic running;
    logic tripped;
    logic trip_condition;
  } seq_out_t;

  // Ramp and limit conditions.
  typedef struct packed {
    logic ramping;
    logic vector_mode;
    logic speed_torque_limit;
    logic vhz_current_limit;
  } drive_cond_t;

endpackage : drive_cmd_pkg

// File: drive_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_seq_model
  import drive_cmd_pkg::*;
(
  // Clock and reset.
  input  wire logic    i_core_clk,
  input  wire logic    i_rst,
  // Sequencer inputs and trip sources.
  input  wire seq_in_t i_cmd,
  input  wire logic    i_trip,
  input  wire logic    i_leave,
  // Sequencer feedback.
  output seq_out_t     o_seq,
  output seq_state_t   o_state
);
  seq_state_t state_q;
  seq_state_t state_d;
  ////////////////////////////////////////////////////////////////////////////
  // Halts win over run, so a dropped interlock always inhibits a start.
  assign state_d = i_trip ? SEQ_TRIPPED :
    (state_q == SEQ_TRIPPED) ? (i_leave ? SEQ_START_INHIBIT : SEQ_TRIPPED) :
    !(i_cmd.coast_stop_n && i_cmd.quick_halt_n) ? SEQ_START_INHIBIT :
    (state_q == SEQ_START_INHIBIT && i_cmd.run_forward) ? SEQ_START_INHIBIT :
    !i_cmd.run_forward ? SEQ_READY_ON :
    i_cmd.drive_operate_enable ? SEQ_ENABLED : SEQ_SWITCHED_ON;
  always_ff @(posedge i_core_clk or posedge i_rst)
    if (i_rst) state_q <= SEQ_START_INHIBIT;
    else state_q <= state_d;
  assign o_state               = state_q;
  assign o_seq.start_permitted = state_q != SEQ_START_INHIBIT && !o_seq.tripped;
  assign o_seq.power_stage_on  = state_q >= SEQ_SWITCHED_ON && !o_seq.tripped;
  assign o_seq.running         = state_q == SEQ_ENABLED;
  assign o_seq.tripped         = state_q >= SEQ_TRIP_ACTIVE;
  assign o_seq.trip_condition  = i_trip;
endmodule : drive_seq_model
`default_nettype wire

// File: drive_control_status_words_bench.sv
`timescale 1ns/1ps
`default_nettype none
module drive_control_status_words_bench;
  import drive_cmd_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, trip = 1'b0, ack, pulse, leave;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, r = 32'habdb;
  logic [15:0] cmd;
  logic [2:0]  mode;
  seq_in_t     loc = '0, sin;
  seq_out_t    seq;
  seq_state_t  st;
  drive_cond_t cond = '0;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0, samples_checked = 0, p, n;
  always #20 clk = ~clk;
  drive_control_status_words drive_control_status_words_i (
    .i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_local(loc), .i_seq(seq),
    .i_seq_state(st), .i_cond(cond), .o_seq_in(sin),
    .o_fault_reset_pulse(pulse), .o_leave_tripped(leave));
  drive_seq_model drive_seq_model_i (
    .i_core_clk(clk), .i_rst(rst), .i_cmd(sin), .i_trip(trip),
    .i_leave(leave), .o_seq(seq), .o_state(st));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic seq_in_t in_exp();
    in_exp = loc;
    if (mode[0]) begin
      in_exp.run_forward = cmd[0];
      in_exp.run_reverse = 1'b0;
      in_exp.stop_hold_n = 1'b0;
      in_exp.coast_stop_n &= cmd[1];
      in_exp.quick_halt_n &= cmd[2];
      in_exp.drive_operate_enable &= cmd[3];
      in_exp.fault_clear = cmd[7];
    end
  endfunction : in_exp
  function automatic logic [31:0] st_exp();
    logic [31:0] s;
    s = 32'h0;
    s[3:0] = {seq.tripped, seq.running, seq.power_stage_on, seq.start_permitted};
    s[4] = mode[0] ? cmd[1] : loc.coast_stop_n;
    s[5] = mode[0] ? cmd[2] : loc.quick_halt_n;
    s[6] = st == SEQ_START_INHIBIT;
    s[9] = mode[1] & mode[2];
    s[10] = !cond.ramping;
    s[11] = cond.vector_mode ? cond.speed_torque_limit : cond.vhz_current_limit;
    return s;
  endfunction : st_exp
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // The request is held until ack is seen or 20 cycles pass; a silent slave costs a mismatch.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    if (ack !== 1'b1) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0) check(rdat, exp_q.pop_front());
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(CMD_WORD_OFS, 32'h0);
    rd(4'h2, 32'h0);
    for (int i = 0; i < 24; i++) begin
      r = lfsr(r);
      cmd = {8'h04, r[16], 3'h7, r[19:17], r[20]};
      mode = r[15:13];
      if (i < 2) begin
        cmd = 16'h047e | 16'(i);
        mode = 3'h1;
      end
      loc <= seq_in_t'(r[6:0]);
      cond <= drive_cond_t'(r[10:7]);
      trip <= r[11] & r[12];
      bus(1'b1, MODE_CTRL_OFS, 32'(mode));
      bus(1'b1, CMD_WORD_OFS, 32'(cmd));
      repeat (6) @(posedge clk);
      check(32'(sin), 32'(in_exp()));
      rd(STATUS_WORD_OFS, st_exp());
      rd(CMD_WORD_OFS, 32'(cmd));
      rd(MODE_CTRL_OFS, 32'(mode));
    end
    loc  <= '0;
    trip <= 1'b1;
    bus(1'b1, MODE_CTRL_OFS, 32'h1);
    bus(1'b1, CMD_WORD_OFS, 32'h047e);
    rd(SEQ_STATE_OFS, 32'(SEQ_TRIPPED));
    trip <= 1'b0;
    repeat (3) @(posedge clk);
    rd(SEQ_STATE_OFS, 32'(SEQ_TRIPPED));
    bus(1'b1, CMD_WORD_OFS, 32'h04fe);
    p = 0;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      if (pulse === 1'b1) p++;
      if (leave === 1'b1) n++;
    end
    check(32'(p), 32'h1);
    check(32'(n), 32'h1);
    rd(SEQ_STATE_OFS, 32'(SEQ_START_INHIBIT));
    summarize();
  end
endmodule : drive_control_status_words_bench
`default_nettype wire
